// File: hw/ldrx_ctrl.sv
// Per-channel receive tuning, loopback and test sequence control block
// What this block does
// RULE1 - Slicer field codes 00..11 give 40/50/60/70 percent, default 01
// RULE2 - Window field codes 00..11 give 32/64/128/256 bits, default 10
// RULE3 - Boost field codes 00..11 give 0/22/26/32 dB, default 0 dB
// RULE4 - Loopback bit 3 enables automatic remote loopback, resets to zero
// RULE5 - Loopback bit 2 forces remote loopback, resets to zero
// RULE6 - Loopback bit 1 enables analog loopback, resets to zero
// RULE7 - Loopback bit 0 enables digital loopback, resets to zero
// RULE8 - Bits 6-5 insert normal/zeros, all ones, pseudo-random or inband
// RULE9 - Bit 4 picks line or master clock; master with 00 sends zeros
// RULE10 - Bit 3 inverts pseudo-random data on transmit and in detector
// RULE11 - Bit 2 picks first or second loss and alarm criterion set
// RULE12 - Bit 1 replaces receive rails and clock with alarm during loss
// RULE13 - Bit 0 with select 00 sends all ones during loss of signal
// RULE14 - Reserved bits read zero; eight channels hold own registers
// RULE15 - Software sets one loopback at once; change clock only when idle
`timescale 1ns/10ps
`default_nettype none

module ldrx_fifo #(
    parameter int W = 5,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ldrx_fifo_st_t;

    ldrx_fifo_st_t st;
    ldrx_fifo_st_t next_st;
    logic push;
    logic pop;

    always_comb begin
        next_st = st;
        in_ready_o = (st.cnt != (AW+1)'(DEPTH));
        out_valid_o = (st.cnt != '0);
        out_data_o = st.mem[st.rp];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (push) begin
            next_st.mem[st.wp] = in_data_i;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : AW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : AW'(st.rp + 1'b1);
        end
        next_st.cnt = (AW+1)'(st.cnt + (AW+1)'(push) - (AW+1)'(pop));
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

module ldrx_ctrl #(
    parameter int MREF_DIV = ldrx_pkg::MREF_DIV_DEF,
    parameter logic [7:0] INBAND_CODE = ldrx_pkg::INBAND_CODE_DEF,
    parameter int INBAND_LEN = ldrx_pkg::INBAND_LEN_DEF,
    parameter int FIFO_DEPTH = ldrx_pkg::FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [ldrx_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Transmit side pins, one per channel
    input wire logic [ldrx_pkg::NCH-1:0] tx_line_clock_i,
    input wire logic [ldrx_pkg::NCH-1:0] tx_data_i,
    input wire logic [ldrx_pkg::NCH-1:0] los_i,
    input wire logic [ldrx_pkg::NCH-1:0] t1_mode_i,
    // Recovered receive rails and clock, one per channel
    input wire logic [ldrx_pkg::NCH-1:0] rx_rec_pos_i,
    input wire logic [ldrx_pkg::NCH-1:0] rx_rec_neg_i,
    input wire logic [ldrx_pkg::NCH-1:0] rx_rec_clk_i,
    output logic [ldrx_pkg::NCH-1:0] rx_data_pos_out_o,
    output logic [ldrx_pkg::NCH-1:0] rx_data_neg_out_o,
    output logic [ldrx_pkg::NCH-1:0] rx_recovered_clock_o,
    // Decoded configuration and detector errors
    output ldrx_pkg::ldrx_cfg_t [ldrx_pkg::NCH-1:0] cfg_o,
    output logic [ldrx_pkg::NCH-1:0] prbs_err_o,
    // Transmit symbol stream
    output ldrx_pkg::ldrx_sym_t sym_o,
    output logic sym_valid_o,
    input wire logic sym_ready_i
);
    ldrx_pkg::ldrx_st_t st;
    ldrx_pkg::ldrx_st_t next_st;
    logic [ldrx_pkg::NCH-1:0] gen_now, gen_bit;
    logic [ldrx_pkg::CH_W-1:0] pick;
    logic any_pend;
    logic fifo_ready;
    logic grant;
    ldrx_pkg::ldrx_sym_t push_sym;
    logic [3:0] chan;
    logic chan_ok;
    logic [7:0] ofs;
    logic [1:0] sel_b;
    logic src_b, los_b, t1_b, tick_b, fb_b, rxb_b;

    assign chan = addr_i[ldrx_pkg::ADDR_W-1:ldrx_pkg::CHAN_LSB];
    assign ofs = addr_i[ldrx_pkg::CHAN_LSB-1:0];
    assign chan_ok = (chan < 4'(ldrx_pkg::NCH));
    assign rdata_o = st.rdata;

    always_comb begin
        next_st = st;
        gen_now = '0;
        gen_bit = '0;
        pick = '0;
        any_pend = 1'b0;
        sel_b = 2'h0;
        src_b = 1'b0;
        los_b = 1'b0;
        t1_b = 1'b0;
        tick_b = 1'b0;
        fb_b = 1'b0;
        rxb_b = 1'b0;
        // Master reference rate as a one-cycle enable
        next_st.mtick = 1'b0;
        if (st.mdiv == 8'(MREF_DIV - 1)) begin
            next_st.mdiv = 8'h00;
            next_st.mtick = 1'b1;
            next_st.aclk = ~st.aclk;
        end else begin
            next_st.mdiv = st.mdiv + 8'h01;
        end
        // Lowest pending channel goes to the FIFO first
        for (int i = ldrx_pkg::NCH - 1; i >= 0; i--) begin
            if (st.ch[i].pend) begin
                pick = ldrx_pkg::CH_W'(i);
                any_pend = 1'b1;
            end
        end
        grant = any_pend && fifo_ready;
        push_sym.chan = pick;
        push_sym.pos = st.ch[pick].pend_pos;
        push_sym.neg = st.ch[pick].pend_neg;
        // Read data stands only in the cycle after the strobe
        next_st.rdata = 8'h00;
        if (rd_i && chan_ok) begin
            if (ofs == ldrx_pkg::OFS_RX_TUNE) begin
                next_st.rdata = st.ch[chan[2:0]].rtc; // [RULE14]
            end else if (ofs == ldrx_pkg::OFS_LOOPBACK) begin
                next_st.rdata = st.ch[chan[2:0]].lb; // [RULE14]
            end else if (ofs == ldrx_pkg::OFS_SEQ_LOSS) begin
                next_st.rdata = st.ch[chan[2:0]].ts; // [RULE14]
            end
        end
        for (int i = 0; i < ldrx_pkg::NCH; i++) begin
            // Pins pass two flops; third stage only for edge finding
            next_st.ch[i].tclk_s = {st.ch[i].tclk_s[1:0], tx_line_clock_i[i]};
            next_st.ch[i].rclk_s = {st.ch[i].rclk_s[1:0], rx_rec_clk_i[i]};
            next_st.ch[i].tdat_s = {st.ch[i].tdat_s[0], tx_data_i[i]};
            next_st.ch[i].los_s = {st.ch[i].los_s[0], los_i[i]};
            next_st.ch[i].t1_s = {st.ch[i].t1_s[0], t1_mode_i[i]};
            next_st.ch[i].rxp_s = {st.ch[i].rxp_s[0], rx_rec_pos_i[i]};
            next_st.ch[i].rxn_s = {st.ch[i].rxn_s[0], rx_rec_neg_i[i]};
            // Each channel keeps its own copy; reserved bits never stored
            if (wr_i && chan_ok && chan[2:0] == ldrx_pkg::CH_W'(i)) begin
                if (ofs == ldrx_pkg::OFS_RX_TUNE) begin
                    next_st.ch[i].rtc = wdata_i & ldrx_pkg::MASK_RX_TUNE; // [RULE14]
                end else if (ofs == ldrx_pkg::OFS_LOOPBACK) begin
                    next_st.ch[i].lb = wdata_i & ldrx_pkg::MASK_LOOPBACK; // [RULE14]
                end else if (ofs == ldrx_pkg::OFS_SEQ_LOSS) begin
                    next_st.ch[i].ts = wdata_i & ldrx_pkg::MASK_SEQ_LOSS; // [RULE14]
                end
            end
            sel_b = st.ch[i].ts[ldrx_pkg::SEQ_SEL_LSB +: 2];
            src_b = st.ch[i].ts[ldrx_pkg::SEQ_CLK_SRC];
            los_b = st.ch[i].los_s[1];
            t1_b = st.ch[i].t1_s[1];
            // Sequence paced by line clock edge or master enable [RULE9]
            tick_b = src_b ? st.mtick
                           : (st.ch[i].tclk_s[1] & ~st.ch[i].tclk_s[2]);
            if (grant && pick == ldrx_pkg::CH_W'(i)) begin
                next_st.ch[i].pend = 1'b0;
            end
            // A tick while the previous symbol still waits is dropped
            if (tick_b && !next_st.ch[i].pend) begin
                gen_now[i] = 1'b1;
                unique case (sel_b)
                    ldrx_pkg::SEQ_NORMAL: begin
                        if (st.ch[i].ts[ldrx_pkg::AUTO_ONES_BIT] && los_b) begin
                            gen_bit[i] = 1'b1; // [RULE13]
                        end else if (src_b) begin
                            gen_bit[i] = 1'b0; // [RULE9]
                        end else begin
                            gen_bit[i] = st.ch[i].tdat_s[1]; // [RULE8]
                        end
                    end
                    ldrx_pkg::SEQ_ONES: begin
                        gen_bit[i] = 1'b1; // [RULE8]
                    end
                    ldrx_pkg::SEQ_PRBS: begin
                        fb_b = ldrx_pkg::ldrx_fb(st.ch[i].gen, t1_b);
                        gen_bit[i] = fb_b
                            ^ st.ch[i].ts[ldrx_pkg::SEQ_INV_BIT]; // [RULE10]
                        next_st.ch[i].gen = {st.ch[i].gen[18:0], fb_b}; // [RULE8]
                    end
                    ldrx_pkg::SEQ_INBAND: begin
                        gen_bit[i] = INBAND_CODE[3'(INBAND_LEN - 1)
                                                 - st.ch[i].icnt]; // [RULE8]
                        next_st.ch[i].icnt =
                            (st.ch[i].icnt == 3'(INBAND_LEN - 1)) ? 3'h0
                            : st.ch[i].icnt + 3'h1;
                    end
                endcase
                // Marks alternate polarity on the two transmit rails
                next_st.ch[i].pend = 1'b1;
                next_st.ch[i].pend_pos = gen_bit[i] & ~st.ch[i].pol;
                next_st.ch[i].pend_neg = gen_bit[i] & st.ch[i].pol;
                if (gen_bit[i]) begin
                    next_st.ch[i].pol = ~st.ch[i].pol;
                end
            end
            // Detector predicts the next bit from its own history
            next_st.ch[i].prbs_err = 1'b0;
            if (st.ch[i].rclk_s[1] & ~st.ch[i].rclk_s[2]) begin
                rxb_b = (st.ch[i].rxp_s[1] | st.ch[i].rxn_s[1])
                      ^ st.ch[i].ts[ldrx_pkg::SEQ_INV_BIT]; // [RULE10]
                next_st.ch[i].det = {st.ch[i].det[18:0], rxb_b};
                next_st.ch[i].prbs_err = (sel_b == ldrx_pkg::SEQ_PRBS)
                    && (rxb_b != ldrx_pkg::ldrx_fb(st.ch[i].det, t1_b));
            end
            if (st.ch[i].ts[ldrx_pkg::AIS_EN_BIT] && los_b) begin
                next_st.ch[i].rxp = 1'b1; // [RULE12]
                next_st.ch[i].rxn = 1'b0; // [RULE12]
                next_st.ch[i].rxc = st.aclk; // [RULE12]
            end else begin
                next_st.ch[i].rxp = st.ch[i].rxp_s[1];
                next_st.ch[i].rxn = st.ch[i].rxn_s[1];
                next_st.ch[i].rxc = st.ch[i].rclk_s[1];
            end
            // Decoded settings for the analog and loopback paths
            cfg_o[i].mark_decision_level_pct =
                ldrx_pkg::ldrx_mark_decision_level_pct(st.ch[i].rtc); // [RULE1]
            cfg_o[i].equalizer_window_len =
                ldrx_pkg::ldrx_window_len(st.ch[i].rtc); // [RULE2]
            cfg_o[i].monitor_boost_db =
                ldrx_pkg::ldrx_boost_db(st.ch[i].rtc); // [RULE3]
            cfg_o[i].auto_remote_loopback =
                st.ch[i].lb[ldrx_pkg::LB_AUTO_REMOTE]; // [RULE4]
            cfg_o[i].remote_loopback = st.ch[i].lb[ldrx_pkg::LB_REMOTE]; // [RULE5]
            cfg_o[i].analog_loopback = st.ch[i].lb[ldrx_pkg::LB_ANALOG]; // [RULE6]
            cfg_o[i].digital_loopback =
                st.ch[i].lb[ldrx_pkg::LB_DIGITAL]; // [RULE7]
            cfg_o[i].loss_criterion_select =
                st.ch[i].ts[ldrx_pkg::LOSS_CRIT_BIT]; // [RULE11]
            rx_data_pos_out_o[i] = st.ch[i].rxp;
            rx_data_neg_out_o[i] = st.ch[i].rxn;
            rx_recovered_clock_o[i] = st.ch[i].rxc;
            prbs_err_o[i] = st.ch[i].prbs_err;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            for (int i = 0; i < ldrx_pkg::NCH; i++) begin
                st.ch[i] <= ldrx_pkg::CH_RST; // [RULE1] [RULE2] [RULE3]
            end
        end else begin
            st <= next_st;
        end
    end

    // Line driver stalls drain the FIFO slowly and hold channels pending
    ldrx_fifo #(
        .W($bits(ldrx_pkg::ldrx_sym_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(any_pend),
        .in_ready_o(fifo_ready),
        .in_data_i(push_sym),
        .out_valid_o(sym_valid_o),
        .out_ready_i(sym_ready_i),
        .out_data_o(sym_o)
    );

    // Checks on channel 0; reserved-bit read check on any channel
    logic wr_tune0, wr_lb0, wr_seq0, auto0, los0;
    logic [1:0] sel0;
    assign wr_tune0 = wr_i && addr_i == {4'h0, ldrx_pkg::OFS_RX_TUNE};
    assign wr_lb0 = wr_i && addr_i == {4'h0, ldrx_pkg::OFS_LOOPBACK};
    assign wr_seq0 = wr_i && addr_i == {4'h0, ldrx_pkg::OFS_SEQ_LOSS};
    assign sel0 = st.ch[0].ts[ldrx_pkg::SEQ_SEL_LSB +: 2];
    assign auto0 = st.ch[0].ts[ldrx_pkg::AUTO_ONES_BIT];
    assign los0 = st.ch[0].los_s[1];

    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_mark_decision_level_top: assert property ( // [RULE1]
        wr_tune0 && wdata_i[5:4] == 2'h3
        |=> cfg_o[0].mark_decision_level_pct == 7'd70)
        else $error("slicer code 11 not 70 percent");
    chk_window_min: assert property ( // [RULE2]
        wr_tune0 && wdata_i[3:2] == 2'h0
        |=> cfg_o[0].equalizer_window_len == 9'd32)
        else $error("window code 00 not 32 bits");
    chk_boost_low: assert property ( // [RULE3]
        wr_tune0 && wdata_i[1:0] == 2'h1
        |=> cfg_o[0].monitor_boost_db == 6'd22)
        else $error("boost code 01 not 22 dB");
    chk_loopback_bits: assert property ( // [RULE4] [RULE5] [RULE6] [RULE7]
        wr_lb0 |=> {4'h0, cfg_o[0].auto_remote_loopback,
            cfg_o[0].remote_loopback, cfg_o[0].analog_loopback,
            cfg_o[0].digital_loopback} == ($past(wdata_i) & 8'h0f))
        else $error("loopback enables differ from written value");
    chk_ones_seq: assert property ( // [RULE8]
        gen_now[0] && sel0 == ldrx_pkg::SEQ_ONES |-> gen_bit[0])
        else $error("all ones sequence sent a zero");
    chk_master_zero: assert property ( // [RULE9]
        gen_now[0] && sel0 == ldrx_pkg::SEQ_NORMAL
        && st.ch[0].ts[ldrx_pkg::SEQ_CLK_SRC] && !(auto0 && los0)
        |-> !gen_bit[0])
        else $error("master clock with select 00 sent a mark");
    chk_pseudo_random_invert: assert property ( // [RULE10]
        gen_now[0] && sel0 == ldrx_pkg::SEQ_PRBS
        |-> gen_bit[0] == (ldrx_pkg::ldrx_fb(st.ch[0].gen, st.ch[0].t1_s[1])
                          ^ st.ch[0].ts[ldrx_pkg::SEQ_INV_BIT]))
        else $error("pseudo-random bit has wrong polarity");
    chk_loss_crit: assert property ( // [RULE11]
        wr_seq0 |=> cfg_o[0].loss_criterion_select == $past(wdata_i[2]))
        else $error("loss criterion select not applied");
    chk_ais_subst: assert property ( // [RULE12]
        st.ch[0].ts[ldrx_pkg::AIS_EN_BIT] && los0
        |=> rx_data_pos_out_o[0] && !rx_data_neg_out_o[0]
            && rx_recovered_clock_o[0] == $past(st.aclk))
        else $error("alarm not substituted on receive outputs");
    chk_auto_ones: assert property ( // [RULE13]
        gen_now[0] && sel0 == ldrx_pkg::SEQ_NORMAL && auto0 && los0
        |-> gen_bit[0])
        else $error("no automatic ones during loss");
    chk_reserved_zero: assert property ( // [RULE14]
        rd_i && addr_i[7:0] == ldrx_pkg::OFS_LOOPBACK
        |=> rdata_o[7:4] == 4'h0 ##1 rdata_o == 8'h00 || $past(rd_i))
        else $error("reserved loopback bits read nonzero");
endmodule

`default_nettype wire

// File: hw/ldrx_pkg.sv
// Constants, types and decode functions for the line diagnostics control
package ldrx_pkg;
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int ADDR_W = 12;
    localparam int CHAN_LSB = 8;
    localparam logic [7:0] OFS_RX_TUNE = 8'h2a;
    localparam logic [7:0] OFS_LOOPBACK = 8'h2b;
    localparam logic [7:0] OFS_SEQ_LOSS = 8'h2c;
    localparam logic [7:0] RST_RX_TUNE = 8'h18;
    localparam logic [7:0] RST_LOOPBACK = 8'h00;
    localparam logic [7:0] RST_SEQ_LOSS = 8'h00;
    localparam logic [7:0] MASK_RX_TUNE = 8'h3f;
    localparam logic [7:0] MASK_LOOPBACK = 8'h0f;
    localparam logic [7:0] MASK_SEQ_LOSS = 8'h7f;
    // Receiver tuning fields
    localparam int MARK_DECISION_LEVEL_LSB = 4;
    localparam int WINDOW_LSB = 2;
    localparam int BOOST_LSB = 0;
    // Loopback control bits
    localparam int LB_AUTO_REMOTE = 3;
    localparam int LB_REMOTE = 2;
    localparam int LB_ANALOG = 1;
    localparam int LB_DIGITAL = 0;
    // Test sequence and loss control bits
    localparam int SEQ_SEL_LSB = 5;
    localparam int SEQ_CLK_SRC = 4;
    localparam int SEQ_INV_BIT = 3;
    localparam int LOSS_CRIT_BIT = 2;
    localparam int AIS_EN_BIT = 1;
    localparam int AUTO_ONES_BIT = 0;
    localparam logic [1:0] SEQ_NORMAL = 2'h0;
    localparam logic [1:0] SEQ_ONES = 2'h1;
    localparam logic [1:0] SEQ_PRBS = 2'h2;
    localparam logic [1:0] SEQ_INBAND = 2'h3;
    // Generator seed, master reference divider, inband code defaults
    localparam logic [19:0] LFSR_SEED = 20'h00001;
    localparam int MREF_DIV_DEF = 12;
    localparam logic [7:0] INBAND_CODE_DEF = 8'h01;
    localparam int INBAND_LEN_DEF = 5;
    localparam int FIFO_DEPTH_DEF = 4;

    typedef struct packed {
        logic [6:0] mark_decision_level_pct;
        logic [8:0] equalizer_window_len;
        logic [5:0] monitor_boost_db;
        logic auto_remote_loopback;
        logic remote_loopback;
        logic analog_loopback;
        logic digital_loopback;
        logic loss_criterion_select;
    } ldrx_cfg_t;

    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic pos;
        logic neg;
    } ldrx_sym_t;

    typedef struct packed {
        logic [7:0] rtc;
        logic [7:0] lb;
        logic [7:0] ts;
        logic [19:0] gen;
        logic [19:0] det;
        logic pol;
        logic [2:0] icnt;
        logic pend;
        logic pend_pos;
        logic pend_neg;
        logic prbs_err;
        logic rxp;
        logic rxn;
        logic rxc;
        logic [2:0] tclk_s;
        logic [2:0] rclk_s;
        logic [1:0] tdat_s;
        logic [1:0] los_s;
        logic [1:0] t1_s;
        logic [1:0] rxp_s;
        logic [1:0] rxn_s;
    } ldrx_ch_t;

    localparam ldrx_ch_t CH_RST = '{rtc: RST_RX_TUNE, lb: RST_LOOPBACK,
        ts: RST_SEQ_LOSS, gen: LFSR_SEED, det: LFSR_SEED, default: '0};

    typedef struct packed {
        ldrx_ch_t [NCH-1:0] ch;
        logic [7:0] mdiv;
        logic mtick;
        logic aclk;
        logic [7:0] rdata;
    } ldrx_st_t;

    function automatic logic [6:0] ldrx_mark_decision_level_pct(input logic [7:0] r);
        logic [1:0] f;
        f = r[MARK_DECISION_LEVEL_LSB +: 2];
        return 7'd40 + 7'(f) * 7'd10;
    endfunction

    function automatic logic [8:0] ldrx_window_len(input logic [7:0] r);
        return 9'd32 << r[WINDOW_LSB +: 2];
    endfunction

    function automatic logic [5:0] ldrx_boost_db(input logic [7:0] r);
        logic [5:0] db;
        unique case (r[BOOST_LSB +: 2])
            2'h0: db = 6'd0;
            2'h1: db = 6'd22;
            2'h2: db = 6'd26;
            2'h3: db = 6'd32;
        endcase
        return db;
    endfunction

    // Feedback of 2^15-1 (E1) or 2^20-1 (T1/J1) shift register
    function automatic logic ldrx_fb(input logic [19:0] g, input logic t1);
        return t1 ? (g[19] ^ g[16]) : (g[14] ^ g[13]);
    endfunction
endpackage

// File: tb/ldrx_sink.sv
// Transmit symbol consumer that stalls at random
`timescale 1ns/10ps
`default_nettype none
module ldrx_sink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Stream handshake
    input wire logic valid_i,
    output logic ready_o
);
    int seed = 29;
    // Stalls let the FIFO fill and refuse while ticks keep coming
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= 1'($random(seed)) | !valid_i;
        end
    end
endmodule
`default_nettype wire

// File: tb/ldrx_ctrl_tb_top.sv
// Self-checking bench for the line diagnostics control block
`timescale 1ns/10ps
`default_nettype none
module ldrx_ctrl_tb_top;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, rd_q = 0, sym_ready_i;
    logic [11:0] addr_i = '0;
    logic [7:0] wdata_i = '0, rdata_o, rdp, rdn, rdc, perr, d;
    logic [7:0] tlc = '0, tdat = '0, los = '0, t1 = '0;
    logic [7:0] rp = '0, rn = '0, rc = '0;
    ldrx_pkg::ldrx_cfg_t [7:0] cfg;
    ldrx_pkg::ldrx_sym_t sym;
    logic sym_valid, last_pos = 0, seen = 0;
    logic [3:0] lb6;
    logic [7:0] rq[$];
    logic [1:0] sq[$];
    logic [1:0] idle_note = '0, note;
    int n_fail = 0, compares = 0, n_marks = 0, seed = 29, m0, k, n_err = 0;
    int sch = 2;
    int bst[4] = '{0, 22, 26, 32};
    assign lb6 = {cfg[6].auto_remote_loopback, cfg[6].remote_loopback,
        cfg[6].analog_loopback, cfg[6].digital_loopback};

    ldrx_ctrl #(.MREF_DIV(2)) dut_u (.clk_i, .nrst_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .tx_line_clock_i(tlc), .tx_data_i(tdat),
        .los_i(los), .t1_mode_i(t1), .rx_rec_pos_i(rp), .rx_rec_neg_i(rn),
        .rx_rec_clk_i(rc), .rx_data_pos_out_o(rdp), .rx_data_neg_out_o(rdn),
        .rx_recovered_clock_o(rdc), .cfg_o(cfg), .prbs_err_o(perr),
        .sym_o(sym), .sym_valid_o(sym_valid), .sym_ready_i);
    ldrx_sink sink_u (.clk_i, .nrst_i, .valid_i(sym_valid),
        .ready_o(sym_ready_i));

    task automatic chk(input string what, input logic [8:0] e, g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 0;
        rd_i <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        rq.push_back(e);
        bus(0, a, 8'h00);
    endtask
    task automatic tick(input logic [1:0] n);
        sq.push_back(n);
        @(posedge clk_i);
        tlc[2] <= 1;
        repeat (5) @(posedge clk_i);
        tlc[2] <= 0;
        repeat (5) @(posedge clk_i);
    endtask

    task automatic rx_bits(input int n);
        repeat (n) begin
            rc[4] <= !rc[4];
            repeat (3) @(posedge clk_i);
        end
    endtask

    // Result watcher: oldest note against each read and each symbol taken
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        if (rd_q) begin
            chk("read data", 9'(rq.pop_front()), 9'(rdata_o));
        end
        if (perr[4] !== 1'b0) n_err++;
        if (sym_valid && sym_ready_i) begin
            note = (sq.size() > 0) ? sq.pop_front() : idle_note;
            chk("symbol channel", 9'(sch), 9'(sym.chan));
            if (note[1]) chk("mark", 9'(note[0]), 9'(sym.pos | sym.neg));
            if (sym.pos | sym.neg) begin
                if (seen) begin
                    chk("alternation", 9'(!last_pos), 9'(sym.pos));
                end
                chk("both rails", 9'h0, 9'(sym.pos & sym.neg));
                last_pos = sym.pos;
                seen = 1;
                n_marks++;
            end
        end
    end

    initial begin
        forever #20 clk_i = !clk_i;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        n_fail++;
        $display("unexpected run length: expected finish, seen hang");
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1;
        rp <= 8'($random(seed));
        rn <= 8'($random(seed));
        t1 <= 8'($random(seed));
        chk("mark_decision_level", 9'd50, 9'(cfg[0].mark_decision_level_pct));
        chk("window", 9'd128, 9'(cfg[0].equalizer_window_len));
        chk("boost", 9'd0, 9'(cfg[0].monitor_boost_db));
        for (k = 0; k < 8; k += 7) begin
            rd({4'(k), ldrx_pkg::OFS_RX_TUNE}, 8'h18);
            rd({4'(k), ldrx_pkg::OFS_LOOPBACK}, 8'h00);
            rd({4'(k), ldrx_pkg::OFS_SEQ_LOSS}, 8'h00);
        end
        $display("reset test done");
        for (k = 0; k < 4; k++) begin
            d = {2'($random(seed)), 2'(k), 2'(k), 2'(k)};
            bus(1, 12'h32a, d);
            rd(12'h32a, d & 8'h3f);
            chk("mark_decision_level", 9'(40 + 10 * k), 9'(cfg[3].mark_decision_level_pct));
            chk("window", 9'(32 << k), 9'(cfg[3].equalizer_window_len));
            chk("boost", 9'(bst[k]), 9'(cfg[3].monitor_boost_db));
            bus(1, 12'h62b, 8'hf0 | (8'h01 << k));
            rd(12'h62b, 8'h01 << k);
            chk("loopback", 9'(1 << k), 9'(lb6));
        end
        bus(1, 12'h82a, 8'h00);
        rd(12'h02a, 8'h18);
        rd(12'h82a, 8'h00);
        rd(12'h02d, 8'h00);
        bus(1, 12'h62c, 8'h84);
        rd(12'h62c, 8'h04);
        chk("criterion", 9'h1, 9'(cfg[6].loss_criterion_select));
        $display("register test done");
        los[5] <= 1;
        repeat (8) @(posedge clk_i);
        chk("rx pos", 9'(rp[4]), 9'(rdp[4]));
        chk("rx neg", 9'(rn[5]), 9'(rdn[5]));
        bus(1, 12'h52c, 8'h02);
        repeat (8) @(posedge clk_i);
        chk("alarm pos", 9'h1, 9'(rdp[5]));
        chk("alarm neg", 9'h0, 9'(rdn[5]));
        $display("alarm test done");
        rp[4] <= 0;
        rn[4] <= 0;
        bus(1, 12'h42c, 8'h40);
        rx_bits(49);
        rd(12'h42c, 8'h40);
        chk("rx clock", 9'h1, 9'(rdc[4]));
        n_err = 0;
        rx_bits(48);
        chk("detector quiet", 9'h0, 9'(n_err));
        bus(1, 12'h42c, 8'h48);
        rx_bits(48);
        chk("detector errors", 9'h1, 9'(n_err > 0));
        $display("detector test done");
        bus(1, 12'h22c, 8'h20);
        repeat (4) tick(2'b11);
        bus(1, 12'h22c, 8'h00);
        tdat[2] <= 1;
        tick(2'b11);
        tdat[2] <= 0;
        tick(2'b10);
        bus(1, 12'h22c, 8'h48);
        repeat (4) tick(2'b11);
        bus(1, 12'h22c, 8'h60);
        m0 = n_marks;
        repeat (10) tick(2'b00);
        repeat (10) @(posedge clk_i);
        chk("inband marks", 9'd2, 9'(n_marks - m0));
        $display("sequence test done");
        bus(1, 12'h22c, 8'h00);
        bus(1, 12'h22c, 8'h10);
        repeat (40) @(posedge clk_i);
        idle_note <= 2'b10;
        repeat (60) @(posedge clk_i);
        idle_note <= 2'b00;
        los[2] <= 1;
        bus(1, 12'h22c, 8'h11);
        repeat (40) @(posedge clk_i);
        idle_note <= 2'b11;
        m0 = n_marks;
        repeat (60) @(posedge clk_i);
        chk("ones seen", 9'h1, 9'(n_marks > m0 + 4));
        $display("master clock test done");
        idle_note <= 2'b00;
        bus(1, 12'h22c, 8'h00);
        repeat (40) @(posedge clk_i);
        sch = 0;
        seen = 0;
        los[0] <= 1;
        bus(1, 12'h02a, 8'h31);
        bus(1, 12'h02b, 8'h08);
        bus(1, 12'h02c, 8'h14);
        bus(1, 12'h02c, 8'h34);
        repeat (40) @(posedge clk_i);
        idle_note <= 2'b11;
        repeat (40) @(posedge clk_i);
        idle_note <= 2'b00;
        bus(1, 12'h02c, 8'h54);
        bus(1, 12'h02c, 8'h14);
        bus(1, 12'h02c, 8'h17);
        repeat (40) @(posedge clk_i);
        chk("alarm pos", 9'h1, 9'(rdp[0]));
        chk("alarm neg", 9'h0, 9'(rdn[0]));
        $display("channel zero test done");
        stop_test();
    end
endmodule
`default_nettype wire
